// *** hw/fpac_flash_ctrl.sv ***
// The implementer's own choices: the register offsets and the APB register port.
`timescale 1ns/1ps
// ====================
// Summary of operation
// - program single byte or up to 32 latched
// - erase one sector, others untouched
// - socket/board modes: sectors 0,1, options, eeprom
// - application mode never alters sector 0
// - link mode boots from system memory vector
// - link data bytes are stored into ram
// - 38 pulses force rc clock, 35 tool clock
// - any reset returns link clock to pull-up input
// - readout protection blocks extraction and writes
// - removing readout protection erases both memories
// - readout protection follows its option bit
// - readout and write protection act independently
// - write protection is permanent, covers sectors 0 and 1 only
// - control register resets zero, three low bits
// - unlock keys are 56h then aeh
module fpac_flash_ctrl
(
  // apb slave
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // programming link pins
  input  wire logic        prog_reset_pin_n,
  input  wire logic        prog_link_clock_pin_i,
  output logic             prog_link_clock_pin_o,
  output logic             prog_link_clock_pin_oe,
  output logic             prog_link_clock_pullup_en,
  input  wire logic        prog_link_data_pin,
  input  wire logic        tool_socket_sel,
  // clocking and boot
  output logic             system_vector_sel,
  output logic             rc_clock_force,
  output logic             external_clock_input_sel,
  output logic             readout_block,
  // ram download
  output logic             ram_wr_stb,
  output logic      [7:0]  ram_wr_addr,
  output logic      [7:0]  ram_wr_data,
  // flash array
  output logic             flash_wr_stb,
  output logic             flash_erase_stb,
  output logic             flash_mass_erase_stb,
  output logic      [1:0]  flash_region,
  output logic      [7:0]  flash_row,
  output logic      [4:0]  flash_idx,
  output logic      [7:0]  flash_wdata,
  input  wire logic        flash_done
);

  typedef struct packed {
    logic [1:0]                rst_s;
    logic [1:0]                clk_s;
    logic [1:0]                dat_s;
    logic [1:0]                sock_s;
    logic                      clk_d;
    logic                      rst_d;
    logic [5:0]                pulse_cnt;
    logic                      board_serial_prog_link;
    logic                      rc_force;
    logic                      socket;
    logic                      option_row_select;
    logic                      lat;
    logic                      program_start;
    fpac_pkg::fpac_key_type    key_st;
    logic                      rop;
    logic                      wp;
    logic [7:0]                row;
    fpac_pkg::fpac_region_type region;
    logic                      erase;
    logic [31:0]               mask;
    logic [4:0]                idx;
    fpac_pkg::fpac_seq_type    seq;
    logic                      refused;
    logic                      lnk_o;
    logic                      lnk_oe;
    logic [7:0]                shift;
    logic [2:0]                bitcnt;
    logic                      ram_stb;
    logic [7:0]                ram_addr;
    logic [7:0]                ram_data;
    logic                      fl_wr;
    logic                      fl_er;
    logic                      fl_mass;
    logic [31:0]               rdata;
  } fpac_state_type;

  localparam fpac_state_type RESET_STATE = '{
    key_st  : fpac_pkg::KEY_LOCKED,
    region  : fpac_pkg::REG_SECT0,
    seq     : fpac_pkg::SQ_IDLE,
    rst_s   : '1, rst_d : 1'b1, clk_s : '1, clk_d : 1'b1,
    default : '0
  };

  fpac_state_type r;
  fpac_state_type n;

  logic       link_rise;
  logic       rst_rise;
  logic       wr_acc;
  logic       rd_setup;
  logic       addr_hit;
  logic       iap_mode;
  logic       mem_we;
  logic [7:0] mem_rdata;
  logic [7:0] wbyte;

  // ====================
  // write permission per region, mode and protection
  function automatic logic may_alter(
    input fpac_pkg::fpac_region_type reg_sel,
    input logic                      application_driven_programming,
    input logic                      rop,
    input logic                      wp
  );
    logic ok;
    ok = 1'b1;
    if (application_driven_programming && (reg_sel == fpac_pkg::REG_SECT0 || reg_sel == fpac_pkg::REG_OPTROW))
    begin
      ok = 1'b0;
    end
    if (rop && reg_sel != fpac_pkg::REG_OPTROW)
    begin
      ok = 1'b0;
    end
    if (wp && (reg_sel == fpac_pkg::REG_SECT0 || reg_sel == fpac_pkg::REG_SECT1))
    begin
      ok = 1'b0;
    end
    may_alter = ok;
  endfunction

  // ====================
  // decode and edge detection
  assign link_rise = r.clk_s[1] & ~r.clk_d;
  assign rst_rise  = r.rst_s[1] & ~r.rst_d;
  assign wr_acc    = psel & penable & pwrite;
  assign rd_setup  = psel & ~penable & ~pwrite;
  assign iap_mode  = ~r.board_serial_prog_link & ~r.socket;
  assign wbyte     = pwdata[7:0];
  assign addr_hit  = (paddr == fpac_pkg::ADDR_CSR) || (paddr == fpac_pkg::ADDR_OPTION) ||
                     (paddr == fpac_pkg::ADDR_TARGET) || (paddr == fpac_pkg::ADDR_LATCH) ||
                     (paddr == fpac_pkg::ADDR_STATUS) || (paddr == fpac_pkg::ADDR_LINKCTL);
  // latches take data only in write mode and never mid-cycle
  assign mem_we    = wr_acc & (paddr == fpac_pkg::ADDR_LATCH) & r.lat & ~r.program_start;

  fpac_latch_mem u_latch
  (
    .pclk  (pclk),
    .we    (mem_we),
    .waddr (pwdata[fpac_pkg::LAT_IDX_LSB +: fpac_pkg::IDX_W]),
    .wdata (pwdata[fpac_pkg::LAT_DAT_LSB +: 8]),
    .raddr (r.idx),
    .rdata (mem_rdata)
  );

  // ====================
  // next state
  always_comb
  begin
    n         = r;
    n.fl_wr   = 1'b0;
    n.fl_er   = 1'b0;
    n.fl_mass = 1'b0;
    n.ram_stb = 1'b0;

    // pins pass two flops before any use
    n.rst_s  = {r.rst_s[0], prog_reset_pin_n};
    n.clk_s  = {r.clk_s[0], prog_link_clock_pin_i};
    n.dat_s  = {r.dat_s[0], prog_link_data_pin};
    n.sock_s = {r.sock_s[0], tool_socket_sel};
    n.clk_d  = r.clk_s[1];
    n.rst_d  = r.rst_s[1];

    // entry: count link clock pulses while the tool holds reset low
    if (!r.rst_s[1])
    begin
      n.lnk_oe   = 1'b0;
      n.lnk_o    = 1'b0;
      n.board_serial_prog_link      = 1'b0;
      n.rc_force = 1'b0;
      if (link_rise && r.pulse_cnt != fpac_pkg::PULSES_MAX)
      begin
        n.pulse_cnt = r.pulse_cnt + 6'h01;
      end
    end
    if (rst_rise)
    begin
      n.socket    = r.sock_s[1];
      n.pulse_cnt = '0;
      n.bitcnt    = '0;
      n.ram_addr  = '0;
      if (r.pulse_cnt == fpac_pkg::PULSES_RC)
      begin
        n.board_serial_prog_link      = 1'b1;
        n.rc_force = 1'b1;
      end
      else if (r.pulse_cnt == fpac_pkg::PULSES_TOOL)
      begin
        n.board_serial_prog_link = 1'b1;
      end
    end

    // serial download: msb first, one byte per eight clocks
    if (r.board_serial_prog_link && r.rst_s[1] && link_rise)
    begin
      n.shift  = {r.shift[6:0], r.dat_s[1]};
      n.bitcnt = r.bitcnt + 3'h1;
      if (r.bitcnt == fpac_pkg::BIT_LAST)
      begin
        n.ram_stb  = 1'b1;
        n.ram_data = {r.shift[6:0], r.dat_s[1]};
      end
    end
    if (r.ram_stb)
    begin
      n.ram_addr = r.ram_addr + 8'h01;
    end

    // register writes
    if (wr_acc)
    begin
      case (paddr)
        fpac_pkg::ADDR_CSR:
        begin
          if (r.key_st == fpac_pkg::KEY_OPEN && !r.program_start)
          begin
            n.option_row_select    = wbyte[fpac_pkg::CSR_OPT];
            n.lat    = wbyte[fpac_pkg::CSR_LAT];
            n.program_start    = wbyte[fpac_pkg::CSR_PGM] & wbyte[fpac_pkg::CSR_LAT];
            n.key_st = fpac_pkg::KEY_LOCKED;
            if (!wbyte[fpac_pkg::CSR_LAT])
            begin
              n.mask = '0;  // dropping write mode empties the latches
            end
          end
          else if (wbyte == fpac_pkg::KEY_FIRST)
          begin
            n.key_st = fpac_pkg::KEY_HALF;
          end
          else if (wbyte == fpac_pkg::KEY_SECOND && r.key_st == fpac_pkg::KEY_HALF)
          begin
            n.key_st = fpac_pkg::KEY_OPEN;
          end
          else
          begin
            n.key_st = fpac_pkg::KEY_LOCKED;
            n.option_row_select    = wbyte[fpac_pkg::CSR_OPT];
          end
        end
        fpac_pkg::ADDR_OPTION:
        begin
          // option row changes follow the same mode gate
          if (!may_alter(fpac_pkg::REG_OPTROW, iap_mode, r.rop, r.wp) ||
              r.seq != fpac_pkg::SQ_IDLE)
          begin
            n.refused = 1'b1;
          end
          else
          begin
            if (pwdata[fpac_pkg::OPT_WP])
            begin
              n.wp = 1'b1;
            end
            if (pwdata[fpac_pkg::OPT_ROP])
            begin
              n.rop = 1'b1;
            end
            else if (r.rop)
            begin
              n.seq     = fpac_pkg::SQ_MASS;
              n.fl_mass = 1'b1;
            end
          end
        end
        fpac_pkg::ADDR_TARGET:
        begin
          if (!r.program_start)
          begin
            n.row    = pwdata[fpac_pkg::TGT_ROW_LSB +: 8];
            n.region = fpac_pkg::fpac_region_type'(pwdata[fpac_pkg::TGT_REG_LSB +: 2]);
            n.erase  = pwdata[fpac_pkg::TGT_ERASE];
          end
        end
        fpac_pkg::ADDR_LATCH:
        begin
          if (mem_we)
          begin
            n.mask[pwdata[fpac_pkg::LAT_IDX_LSB +: fpac_pkg::IDX_W]] = 1'b1;
          end
        end
        fpac_pkg::ADDR_STATUS:
        begin
          if (pwdata[fpac_pkg::ST_REFUSED])
          begin
            n.refused = 1'b0;
          end
        end
        fpac_pkg::ADDR_LINKCTL:
        begin
          n.lnk_o  = pwdata[fpac_pkg::LNK_OUT];
          n.lnk_oe = pwdata[fpac_pkg::LNK_OE] & r.rst_s[1];
        end
        default:
        begin
          n.refused = n.refused;
        end
      endcase
    end

    // sequencer
    case (r.seq)
      fpac_pkg::SQ_IDLE:
      begin
        if (r.program_start)
        begin
          if (!may_alter(r.option_row_select ? fpac_pkg::REG_OPTROW : r.region, iap_mode, r.rop, r.wp))
          begin
            n.refused = 1'b1;
            n.program_start     = 1'b0;
            n.lat     = 1'b0;
            n.mask    = '0;
          end
          else if (r.erase)
          begin
            n.seq   = fpac_pkg::SQ_ERASE;
            n.fl_er = 1'b1;
          end
          else
          begin
            n.seq = fpac_pkg::SQ_SCAN;
            n.idx = '0;
          end
        end
      end
      fpac_pkg::SQ_SCAN:
      begin
        // empty latch slots are skipped, so one byte or up to 32
        if (r.mask[r.idx])
        begin
          n.seq = fpac_pkg::SQ_ISSUE;
        end
        else if (r.idx == fpac_pkg::IDX_LAST)
        begin
          n.seq  = fpac_pkg::SQ_IDLE;
          n.program_start  = 1'b0;
          n.lat  = 1'b0;
          n.mask = '0;
        end
        else
        begin
          n.idx = r.idx + 5'h01;
        end
      end
      fpac_pkg::SQ_ISSUE:
      begin
        n.fl_wr = 1'b1;
        n.seq   = fpac_pkg::SQ_WAIT;
      end
      fpac_pkg::SQ_WAIT:
      begin
        if (flash_done)
        begin
          n.mask[r.idx] = 1'b0;
          n.seq         = fpac_pkg::SQ_SCAN;
        end
      end
      fpac_pkg::SQ_ERASE:
      begin
        if (flash_done)
        begin
          n.seq  = fpac_pkg::SQ_IDLE;
          n.program_start  = 1'b0;
          n.lat  = 1'b0;
          n.mask = '0;
        end
      end
      fpac_pkg::SQ_MASS:
      begin
        // protection only lifts once both memories are blank
        if (flash_done)
        begin
          n.seq = fpac_pkg::SQ_IDLE;
          n.rop = 1'b0;
        end
      end
      default:
      begin
        n.seq = fpac_pkg::SQ_IDLE;
      end
    endcase

    // read data captured in setup, presented in access
    n.rdata = '0;
    if (rd_setup)
    begin
      case (paddr)
        fpac_pkg::ADDR_CSR:
        begin
          n.rdata[fpac_pkg::CSR_OPT] = r.option_row_select;
          n.rdata[fpac_pkg::CSR_LAT] = r.lat;
          n.rdata[fpac_pkg::CSR_PGM] = r.program_start;
        end
        fpac_pkg::ADDR_OPTION:
        begin
          n.rdata[fpac_pkg::OPT_ROP] = r.rop;
          n.rdata[fpac_pkg::OPT_WP]  = r.wp;
        end
        fpac_pkg::ADDR_TARGET:
        begin
          n.rdata[fpac_pkg::TGT_ROW_LSB +: 8] = r.row;
          n.rdata[fpac_pkg::TGT_REG_LSB +: 2] = r.region;
          n.rdata[fpac_pkg::TGT_ERASE]        = r.erase;
        end
        fpac_pkg::ADDR_STATUS:
        begin
          n.rdata[fpac_pkg::ST_REFUSED] = r.refused;
          n.rdata[fpac_pkg::ST_BUSY]    = (r.seq != fpac_pkg::SQ_IDLE);
          n.rdata[fpac_pkg::ST_ICC]     = r.board_serial_prog_link;
          n.rdata[fpac_pkg::ST_RC]      = r.rc_force;
          n.rdata[fpac_pkg::ST_SOCKET]  = r.socket;
          n.rdata[fpac_pkg::ST_IAP]     = iap_mode;
          n.rdata[fpac_pkg::ST_KEYOPEN] = (r.key_st == fpac_pkg::KEY_OPEN);
          n.rdata[fpac_pkg::ST_ROP]     = r.rop;
          n.rdata[fpac_pkg::ST_WP]      = r.wp;
        end
        fpac_pkg::ADDR_LINKCTL:
        begin
          n.rdata[fpac_pkg::LNK_OUT] = r.lnk_o;
          n.rdata[fpac_pkg::LNK_OE]  = r.lnk_oe;
        end
        default:
        begin
          n.rdata = '0;  // latches are write only
        end
      endcase
    end
  end

  // ====================
  // state register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      r <= RESET_STATE;
    end
    else
    begin
      r <= n;
    end
  end

  // ====================
  // outputs
  assign prdata                    = r.rdata;
  assign pready                    = 1'b1;
  assign pslverr                   = psel & penable & ~addr_hit;
  assign prog_link_clock_pin_o     = r.lnk_o;
  assign prog_link_clock_pin_oe    = r.lnk_oe;
  assign prog_link_clock_pullup_en = ~r.lnk_oe;
  assign system_vector_sel         = r.board_serial_prog_link;
  assign rc_clock_force            = r.rc_force;
  assign external_clock_input_sel  = r.board_serial_prog_link & ~r.rc_force;
  assign readout_block             = r.rop;
  assign ram_wr_stb                = r.ram_stb;
  assign ram_wr_addr               = r.ram_addr;
  assign ram_wr_data               = r.ram_data;
  assign flash_wr_stb              = r.fl_wr;
  assign flash_erase_stb           = r.fl_er;
  assign flash_mass_erase_stb      = r.fl_mass;
  assign flash_region              = r.option_row_select ? fpac_pkg::REG_OPTROW : r.region;
  assign flash_row                 = r.row;
  assign flash_idx                 = r.idx;
  assign flash_wdata               = mem_rdata;

endmodule

// *** hw/fpac_pkg.sv ***
// ====================
// flash access control constants
package fpac_pkg;

  // ====================
  // register map (byte addresses)
  localparam int unsigned ADDR_W       = 8;
  localparam logic [7:0]  ADDR_CSR     = 8'h00;
  localparam logic [7:0]  ADDR_OPTION  = 8'h04;
  localparam logic [7:0]  ADDR_TARGET  = 8'h08;
  localparam logic [7:0]  ADDR_LATCH   = 8'h0c;
  localparam logic [7:0]  ADDR_STATUS  = 8'h10;
  localparam logic [7:0]  ADDR_LINKCTL = 8'h14;

  // ====================
  // control/status register
  localparam logic [7:0]  CSR_RESET = 8'h00;
  localparam int unsigned CSR_OPT   = 2;
  localparam int unsigned CSR_LAT   = 1;
  localparam int unsigned CSR_PGM   = 0;
  localparam logic [7:0]  KEY_FIRST  = 8'h56;
  localparam logic [7:0]  KEY_SECOND = 8'hae;

  // ====================
  // option, target, latch, status and link fields
  localparam int unsigned OPT_ROP    = 0;
  localparam int unsigned OPT_WP     = 1;
  localparam int unsigned TGT_ROW_LSB = 0;
  localparam int unsigned TGT_REG_LSB = 8;
  localparam int unsigned TGT_ERASE  = 12;
  localparam int unsigned LAT_DAT_LSB = 0;
  localparam int unsigned LAT_IDX_LSB = 8;
  localparam int unsigned ST_REFUSED = 0;
  localparam int unsigned ST_BUSY    = 1;
  localparam int unsigned ST_ICC     = 2;
  localparam int unsigned ST_RC      = 3;
  localparam int unsigned ST_SOCKET  = 4;
  localparam int unsigned ST_IAP     = 5;
  localparam int unsigned ST_KEYOPEN = 6;
  localparam int unsigned ST_ROP     = 7;
  localparam int unsigned ST_WP      = 8;
  localparam int unsigned LNK_OUT    = 0;
  localparam int unsigned LNK_OE     = 1;

  // ====================
  // latch buffer and entry sequence
  localparam int unsigned LATCH_DEPTH = 32;
  localparam int unsigned IDX_W       = 5;
  localparam logic [4:0]  IDX_LAST    = 5'h1f;
  localparam logic [5:0]  PULSES_RC   = 6'h26;  // 38 pulses
  localparam logic [5:0]  PULSES_TOOL = 6'h23;  // 35 pulses
  localparam logic [5:0]  PULSES_MAX  = 6'h3f;
  localparam logic [2:0]  BIT_LAST    = 3'h7;

  // ====================
  // types
  typedef enum logic [1:0] {
    REG_SECT0  = 2'h0,
    REG_SECT1  = 2'h1,
    REG_OPTROW = 2'h2,
    REG_EEPROM = 2'h3
  } fpac_region_type;

  typedef enum logic [1:0] {
    KEY_LOCKED = 2'h0,
    KEY_HALF   = 2'h1,
    KEY_OPEN   = 2'h2
  } fpac_key_type;

  typedef enum logic [5:0] {
    SQ_IDLE  = 6'h01,
    SQ_SCAN  = 6'h02,
    SQ_ISSUE = 6'h04,
    SQ_WAIT  = 6'h08,
    SQ_ERASE = 6'h10,
    SQ_MASS  = 6'h20
  } fpac_seq_type;

endpackage

// *** hw/fpac_latch_mem.sv ***
`timescale 1ns/1ps
// ====================
// 32-byte write latch buffer, registered read
module fpac_latch_mem
(
  // clock
  input  wire logic       pclk,
  // write port
  input  wire logic       we,
  input  wire logic [4:0] waddr,
  input  wire logic [7:0] wdata,
  // read port
  input  wire logic [4:0] raddr,
  output logic      [7:0] rdata
);

  logic [7:0] mem [fpac_pkg::LATCH_DEPTH];

  // no reset: content is qualified by the valid mask upstream
  always_ff @(posedge pclk)
  begin
    if (we)
    begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end

endmodule

// *** sim/fpac_flash_ctrl_props.sv ***
`timescale 1ns/1ps
// ====================
// port-level checks for the flash access controller
module fpac_flash_ctrl_props
(
  // apb side
  input logic        pclk,
  input logic        presetn,
  input logic        psel,
  input logic        penable,
  input logic        pwrite,
  input logic [7:0]  paddr,
  input logic [31:0] pwdata,
  // link pins and modes
  input logic        prog_reset_pin_n,
  input logic        prog_link_clock_pin_oe,
  input logic        prog_link_clock_pullup_en,
  input logic        tool_socket_sel,
  input logic        system_vector_sel,
  input logic        rc_clock_force,
  input logic        external_clock_input_sel,
  input logic        readout_block,
  input logic        ram_wr_stb,
  // flash array
  input logic        flash_wr_stb,
  input logic        flash_erase_stb,
  input logic        flash_mass_erase_stb,
  input logic [1:0]  flash_region
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // option register write taken in this cycle
  logic opt_wr;
  assign opt_wr = psel && penable && pwrite && paddr == fpac_pkg::ADDR_OPTION;

  // ====================
  // six low samples leave room for the pin synchroniser
  property p_pin_rst;
    !prog_reset_pin_n [*6] |-> !prog_link_clock_pin_oe && prog_link_clock_pullup_en;
  endproperty
  a_pin_rst: assert property (p_pin_rst)
    else $error("link pin not released");
  property p_app_sect0;
    (flash_wr_stb || flash_erase_stb) && flash_region == 2'h0 && !tool_socket_sel
      |-> system_vector_sel;
  endproperty
  a_app_sect0: assert property (p_app_sect0)
    else $error("sector 0 altered");
  property p_rop_block;
    (flash_wr_stb || flash_erase_stb) && flash_region != 2'h2 |-> !readout_block;
  endproperty
  a_rop_block: assert property (p_rop_block)
    else $error("altered while protected");
  property p_rc_mode;
    rc_clock_force |-> system_vector_sel && !external_clock_input_sel;
  endproperty
  a_rc_mode: assert property (p_rc_mode)
    else $error("bad clock select");
  property p_ram_byte;
    ram_wr_stb |-> system_vector_sel ##1 !ram_wr_stb;
  endproperty
  a_ram_byte: assert property (p_ram_byte)
    else $error("stray ram strobe");
  property p_mass;
    flash_mass_erase_stb |-> $past(opt_wr && !pwdata[0] && readout_block);
  endproperty
  a_mass: assert property (p_mass)
    else $error("stray mass erase");
  property p_one_erase;
    flash_erase_stb |-> !flash_wr_stb && !flash_mass_erase_stb ##1 !flash_erase_stb;
  endproperty
  a_one_erase: assert property (p_one_erase)
    else $error("erase overlap");
  property p_rop_set;
    $rose(readout_block) |-> $past(opt_wr && pwdata[0]);
  endproperty
  a_rop_set: assert property (p_rop_set)
    else $error("stray readout lock");
endmodule

bind fpac_flash_ctrl fpac_flash_ctrl_props u_props (.*);

// *** sim/fpac_tool_model.sv ***
`timescale 1ns/1ps
// ====================
// programming tool: owns the reset pin and both link pins
module fpac_tool_model
(
  // pins driven by the tool
  output logic rst_n,
  output logic lclk,
  output logic ldat
);
  // link clock half period; the link stands still between frames
  localparam time HALF = 80ns;

  // idle: reset released, pins at their pulled-up level
  initial
  begin
    rst_n = 1'b1;
    lclk = 1'b1;
    ldat = 1'b1;
  end

  // one link clock pulse, low then high
  task automatic pulse;
    lclk = 1'b0;
    #HALF;
    lclk = 1'b1;
    #HALF;
  endtask

  // mode entry: pulses are counted while the tool holds reset low
  task automatic enter(input int n);
    rst_n = 1'b0;
    #(4 * HALF);
    repeat (n) pulse();
    #(4 * HALF);
    rst_n = 1'b1;
    #(4 * HALF);
  endtask

  // one download byte, msb first, data set ahead of the rising edge
  task automatic send(input logic [7:0] b);
    for (int i = 7; i >= 0; i--)
    begin
      ldat = b[i];
      pulse();
    end
    ldat = 1'b1; // released line falls back to the pull-up level
  endtask
endmodule

// *** sim/testbench.sv ***
`timescale 1ns/1ps
// ====================
// register-level bench for the flash access controller
module testbench;
  logic        pclk = 1'b0, presetn = 1'b0, flash_done = 1'b0, tool_clk, e;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
  logic [7:0]  paddr = 8'h00, ram_wr_addr, ram_wr_data, flash_row, flash_wdata;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic        prog_reset_pin_n, prog_link_data_pin, prog_link_clock_pin_o;
  logic        prog_link_clock_pin_oe, prog_link_clock_pullup_en, system_vector_sel;
  logic        rc_clock_force, external_clock_input_sel, readout_block, ram_wr_stb;
  logic        flash_wr_stb, flash_erase_stb, flash_mass_erase_stb;
  logic [4:0]  flash_idx;
  logic [1:0]  flash_region;
  logic [22:0] last_w;
  logic [15:0] last_ram;
  logic        tool_socket_sel = 1'b0; // strap low
  int          bad_count = 0, n_checks = 0, wr_n = 0, er_n = 0, ms_n = 0, ram_n = 0;
  // device level while it drives, else the tool's
  wire         prog_link_clock_pin_i =
               prog_link_clock_pin_oe ? prog_link_clock_pin_o : tool_clk;

  fpac_flash_ctrl dut (.*);
  fpac_tool_model tool (.rst_n(prog_reset_pin_n), .lclk(tool_clk), .ldat(prog_link_data_pin));

  always #2 pclk = ~pclk;

  // ====================
  // flash stand-in: done a cycle after each strobe
  always @(posedge pclk)
  begin
    flash_done <= flash_wr_stb | flash_erase_stb | flash_mass_erase_stb;
    wr_n += int'(flash_wr_stb === 1'b1);
    er_n += int'(flash_erase_stb === 1'b1);
    ms_n += int'(flash_mass_erase_stb === 1'b1);
    ram_n += int'(ram_wr_stb === 1'b1);
    if (flash_wr_stb === 1'b1)
      last_w <= {flash_row, flash_region, flash_idx, flash_wdata};
    if (ram_wr_stb === 1'b1)
      last_ram <= {ram_wr_addr, ram_wr_data};
  end

  // ====================
  // verdict and comparison
  task automatic end_sim;
    if (bad_count == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  // ====================
  // apb master: access held until pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (n >= 20)
    begin
      bad_count++;
      end_sim();
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(q, x);
  endtask
  // both keys, then the value that they unlock
  task automatic keys(input logic [7:0] v);
    wr(fpac_pkg::ADDR_CSR, {24'h0, fpac_pkg::KEY_FIRST});
    wr(fpac_pkg::ADDR_CSR, {24'h0, fpac_pkg::KEY_SECOND});
    wr(fpac_pkg::ADDR_CSR, {24'h0, v});
  endtask
  // one pass on row 07, polled until pgm drops
  task automatic prog(input logic er, input logic [1:0] rg, input logic [4:0] ix,
                      input logic [7:0] dt);
    int n;
    wr(fpac_pkg::ADDR_TARGET, {19'h0, er, 2'h0, rg, 8'h07});
    keys(8'h02);
    wr(fpac_pkg::ADDR_LATCH, {19'h0, ix, dt});
    keys(8'h03);
    n = 0;
    do
    begin
      apb(1'b0, fpac_pkg::ADDR_CSR, 32'h0);
      n++;
    end
    while (q[1:0] !== 2'b00 && n < 200);
    if (n >= 200)
    begin
      bad_count++;
      end_sim();
    end
  endtask

  // ====================
  // main sequence
  initial
  begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk({prog_link_clock_pullup_en, prog_link_clock_pin_oe}, 2'b10);
    rdc(fpac_pkg::ADDR_CSR, 32'h0);
    apb(1'b0, 8'h20, 32'h0);
    chk({q[30:0], e}, 32'h1);
    // wrong key order leaves the latch bit closed
    wr(fpac_pkg::ADDR_CSR, 32'hae);
    wr(fpac_pkg::ADDR_CSR, 32'h56);
    wr(fpac_pkg::ADDR_CSR, 32'h02);
    apb(1'b0, fpac_pkg::ADDR_CSR, 32'h0);
    chk(q & 32'h3, 32'h0);
    keys(8'h02);
    rdc(fpac_pkg::ADDR_CSR, 32'h2);
    keys(8'h00);
    // application mode: sector 0 and options refused, sector 1 written
    prog(1'b0, 2'h0, 5'h00, 8'h11);
    wr(fpac_pkg::ADDR_OPTION, 32'h1);
    chk({wr_n[30:0], readout_block}, 32'h0);
    rdc(fpac_pkg::ADDR_STATUS, 32'h21);
    wr(fpac_pkg::ADDR_STATUS, 32'h1);
    rdc(fpac_pkg::ADDR_STATUS, 32'h20);
    keys(8'h02);
    wr(fpac_pkg::ADDR_LATCH, 32'h035a);
    prog(1'b0, 2'h1, 5'h1f, 8'h3c);
    chk(wr_n, 2);
    chk(last_w, {8'h07, 2'h1, 5'h1f, 8'h3c});
    rdc(fpac_pkg::ADDR_CSR, 32'h0);
    prog(1'b1, 2'h1, 5'h00, 8'h00);
    keys(8'h00);
    chk({er_n[15:0], wr_n[15:0]}, 32'h00010002);
    // 38-pulse entry, then one byte downloaded
    tool.enter(38);
    @(posedge pclk);
    chk({system_vector_sel, rc_clock_force, external_clock_input_sel}, 3'b110);
    rdc(fpac_pkg::ADDR_STATUS, 32'h0c);
    tool.send(8'hc3);
    @(posedge pclk);
    chk({ram_n[15:0], last_ram}, 32'h000100c3);
    // device drives the link clock until the next reset
    wr(fpac_pkg::ADDR_LINKCTL, 32'h3);
    @(posedge pclk);
    chk({prog_link_clock_pullup_en, prog_link_clock_pin_oe, prog_link_clock_pin_o}, 3'b011);
    tool.enter(35);
    @(posedge pclk);
    chk({prog_link_clock_pullup_en, prog_link_clock_pin_oe}, 2'b10);
    chk({system_vector_sel, rc_clock_force, external_clock_input_sel}, 3'b101);
    // board mode: sector 0 open, then readout protection on and off
    prog(1'b0, 2'h0, 5'h04, 8'h77);
    chk(wr_n, 3);
    wr(fpac_pkg::ADDR_OPTION, 32'h1);
    prog(1'b0, 2'h1, 5'h04, 8'h77);
    chk({wr_n[30:0], readout_block}, 32'h7);
    rdc(fpac_pkg::ADDR_STATUS, 32'h85);
    wr(fpac_pkg::ADDR_STATUS, 32'h1);
    wr(fpac_pkg::ADDR_OPTION, 32'h0);
    apb(1'b0, fpac_pkg::ADDR_STATUS, 32'h0);
    rdc(fpac_pkg::ADDR_STATUS, 32'h04);
    chk({ms_n[3:0], readout_block}, 5'h02);
    // write protection sticks; eeprom stays writable
    wr(fpac_pkg::ADDR_OPTION, 32'h2);
    wr(fpac_pkg::ADDR_OPTION, 32'h0);
    rdc(fpac_pkg::ADDR_STATUS, 32'h104);
    prog(1'b0, 2'h1, 5'h02, 8'h99);
    prog(1'b0, 2'h3, 5'h02, 8'h99);
    chk(wr_n, 4);
    chk(last_w, {8'h07, 2'h3, 5'h02, 8'h99});
    end_sim();
  end
endmodule
